//--- rtl/cpu_flags_pkg.sv
// shared constants and types of the flag and address-mode block
// assumes one clock domain; no bus, all state is reached by ports
package cpu_flags_pkg;
	// ------------------------------------------------------------
	// flag register layout
	// ------------------------------------------------------------
	localparam int BIT_C = 0;
	localparam int BIT_V = 1;
	localparam int BIT_Z = 2;
	localparam int BIT_N = 3;
	localparam int BIT_I = 4;
	localparam int BIT_H = 5;
	localparam int BIT_X = 6;
	localparam int BIT_S = 7;
	localparam logic [7:0] FLAGS_RESET = 8'hD0;

	// ------------------------------------------------------------
	// opcode paging and address forming
	// ------------------------------------------------------------
	localparam logic [7:0] PREBYTE_P1 = 8'h18;
	localparam logic [7:0] PREBYTE_P2 = 8'h1A;
	localparam logic [7:0] PREBYTE_P3 = 8'hCD;
	localparam logic [7:0] OPC_BSR    = 8'h8D;
	localparam logic [7:0] DIRECT_HI  = 8'h00;
	localparam logic [7:0] HI_ZERO    = 8'h00;
	localparam logic [15:0] ALL_ONES  = 16'hFFFF;
	localparam logic [15:0] ONE16     = 16'h0001;
	localparam logic [2:0] LEN_ONE    = 3'h1;

	typedef enum logic [1:0] {PAGE0, PAGE1, PAGE2, PAGE3} page_t;
	typedef enum logic [2:0] {
		MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IND, MODE_REL
	} mode_t;

	typedef enum logic [4:0] {
		OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_AND, OP_OR,
		OP_EOR, OP_LOAD, OP_INC_IDX, OP_DEC_IDX, OP_ADD_B_IDX, OP_XFER,
		OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_MUL, OP_DIV, OP_TAP, OP_RTI,
		OP_CLI, OP_SEI, OP_IRQ_ACK, OP_NONMASKABLE_REQUEST_PIN_ACK, OP_STOP
	} alu_op_t;
endpackage

//--- rtl/addr_if.sv
// carrier between the instruction decoder and the address former
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface addr_if;
	cpu_flags_pkg::mode_t mode;
	logic                 use_y;
	logic                 taken;
	logic [7:0]           byte0;
	logic [7:0]           byte1;
	logic [15:0]          first_idx;
	logic [15:0]          second_idx;
	logic [15:0]          imm_addr;
	logic [15:0]          next_addr;
	logic [15:0]          ea;
	logic                 ea_en;
	modport dec (output mode, use_y, taken, byte0, byte1, first_idx,
		second_idx, imm_addr, next_addr, input ea, ea_en);
	modport calc (input mode, use_y, taken, byte0, byte1, first_idx,
		second_idx, imm_addr, next_addr, output ea, ea_en);
endinterface

//--- rtl/ea_former.sv
// effective address former, purely combinational
// assumes operand bytes and addresses are held stable by the decoder
`timescale 1ns/10ps
module ea_former (
	addr_if.calc port
);
	// ------------------------------------------------------------
	// address per mode
	// ------------------------------------------------------------
	wire [15:0] idx_w   = port.use_y ? port.second_idx : port.first_idx;
	wire [15:0] ind_w   = idx_w + {cpu_flags_pkg::HI_ZERO, port.byte0};
	wire [15:0] rel_w   = port.next_addr + {{8{port.byte0[7]}}, port.byte0};

	always_comb begin
		port.ea_en = 1'b1;
		case (port.mode)
			cpu_flags_pkg::MODE_IMM: port.ea = port.imm_addr;
			cpu_flags_pkg::MODE_DIR: begin
				port.ea = {cpu_flags_pkg::DIRECT_HI, port.byte0};
			end
			cpu_flags_pkg::MODE_EXT: begin
				port.ea = {port.byte0, port.byte1};
			end
			cpu_flags_pkg::MODE_IND: port.ea = ind_w;
			cpu_flags_pkg::MODE_REL: begin
				port.ea = port.taken ? rel_w : port.next_addr;
			end
			default: begin
				port.ea    = port.next_addr;
				port.ea_en = 1'b0;
			end
		endcase
	end
endmodule

//--- rtl/cpu_flags_and_address_modes.sv
// flag register, interrupt masks, stop veto and operand address decoding
// assumes bytes arrive from the memory bus on core_clk_i; request pins
// are asynchronous and synchronised here
`timescale 1ns/10ps
module cpu_flags_and_address_modes (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  irq_request_n_i,
	input  wire logic                  nonmaskable_request_pin_n_i,
	input  wire logic                  fetch_valid_i,
	input  wire logic [7:0]            fetch_byte_i,
	input  wire logic [15:0]           fetch_addr_i,
	input  wire logic [15:0]           first_index_reg_i,
	input  wire logic [15:0]           second_index_reg_i,
	input  wire logic                  op_valid_i,
	input  wire cpu_flags_pkg::alu_op_t op_i,
	input  wire logic                  op_wide_i,
	input  wire logic [15:0]           opa_i,
	input  wire logic [15:0]           opb_i,
	output logic                       fetch_ready_o,
	output logic                       decode_done_o,
	output cpu_flags_pkg::page_t       page_o,
	output logic [7:0]                 opcode_o,
	output cpu_flags_pkg::mode_t       mode_o,
	output logic [2:0]                 instr_len_o,
	output logic [15:0]                ea_o,
	output logic                       ea_valid_o,
	output logic                       branch_taken_o,
	output logic [15:0]                result_o,
	output logic                       result_we_o,
	output logic [7:0]                 condition_flags_register_o,
	output logic                       irq_take_o,
	output logic                       nonmaskable_request_pin_take_o,
	output logic                       stop_enter_o,
	output logic                       stop_nop_o
);
	import cpu_flags_pkg::*;

	// ------------------------------------------------------------
	// reset release and pin synchronisers
	// ------------------------------------------------------------
	logic rst_q1, rst_n, irq_q1, irq_q2, nonmaskable_request_pin_q1, nonmaskable_request_pin_q2;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end
	// idle level of both active-low pins is high
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_q1  <= 1'b1;
			irq_q2  <= 1'b1;
			nonmaskable_request_pin_q1 <= 1'b1;
			nonmaskable_request_pin_q2 <= 1'b1;
		end else begin
			irq_q1  <= irq_request_n_i;
			irq_q2  <= irq_q1;
			nonmaskable_request_pin_q1 <= nonmaskable_request_pin_n_i;
			nonmaskable_request_pin_q2 <= nonmaskable_request_pin_q1;
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic top_bit(input logic [15:0] v, input logic w);
		top_bit = w ? v[15] : v[7];
	endfunction
	function automatic logic is_zero(input logic [15:0] v, input logic w);
		is_zero = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
	endfunction
	function automatic logic [15:0] fit(input logic [15:0] v,
		input logic w);
		fit = w ? v : {HI_ZERO, v[7:0]};
	endfunction
	function automatic logic carry_at(input logic [16:0] v, input logic w);
		carry_at = w ? v[16] : v[8];
	endfunction
	function automatic logic cond_true(input logic [3:0] c,
		input logic [7:0] f);
		logic n_x_v;
		n_x_v = f[BIT_N] ^ f[BIT_V];
		case (c)
			4'h0: cond_true = 1'b1;
			4'h1: cond_true = 1'b0;
			4'h2: cond_true = !(f[BIT_C] | f[BIT_Z]);
			4'h3: cond_true = f[BIT_C] | f[BIT_Z];
			4'h4: cond_true = !f[BIT_C];
			4'h5: cond_true = f[BIT_C];
			4'h6: cond_true = !f[BIT_Z];
			4'h7: cond_true = f[BIT_Z];
			4'h8: cond_true = !f[BIT_V];
			4'h9: cond_true = f[BIT_V];
			4'hA: cond_true = !f[BIT_N];
			4'hB: cond_true = f[BIT_N];
			4'hC: cond_true = !n_x_v;
			4'hD: cond_true = n_x_v;
			4'hE: cond_true = !(f[BIT_Z] | n_x_v);
			default: cond_true = f[BIT_Z] | n_x_v;
		endcase
	endfunction

	// ------------------------------------------------------------
	// flag register update
	// ------------------------------------------------------------
	logic [7:0]  ccr_q, ccr_d;
	logic [15:0] result_q, result_d;
	logic        we_q, we_d, stop_enter_q, stop_nop_q;
	wire c_in      = ccr_q[BIT_C];
	wire add_cin   = (op_i == OP_ADC) & c_in;
	wire sub_cin   = (op_i == OP_SBC) & c_in;
	wire [16:0] sum_w = {1'b0, opa_i} + {1'b0, opb_i} + {16'h0000, add_cin};
	wire [16:0] dif_w = {1'b0, opa_i} - {1'b0, opb_i} - {16'h0000, sub_cin};
	wire [15:0] sum_r = fit(sum_w[15:0], op_wide_i);
	wire [15:0] dif_r = fit(dif_w[15:0], op_wide_i);
	wire a_m = top_bit(opa_i, op_wide_i);
	wire b_m = top_bit(opb_i, op_wide_i);
	wire half_w = (opa_i[3] & opb_i[3]) | (opb_i[3] & !sum_w[3])
		| (!sum_w[3] & opa_i[3]);
	wire rot_in = (op_i == OP_ROL || op_i == OP_ROR) & c_in;
	wire [15:0] shl_w = fit({opa_i[14:0], rot_in}, op_wide_i);
	wire [15:0] shr_w = op_wide_i ? {rot_in, opa_i[15:1]}
		: {HI_ZERO, rot_in, opa_i[7:1]};
	wire is_left  = (op_i == OP_ASL) | (op_i == OP_ROL);
	wire [15:0] sh_r   = is_left ? shl_w : shr_w;
	wire sh_c     = is_left ? a_m : opa_i[0];
	wire [15:0] mul_w  = opa_i[7:0] * opb_i[7:0];
	wire div_zero = (opb_i == 16'h0000);
	wire [15:0] div_w  = div_zero ? ALL_ONES : opa_i / opb_i;
	wire [15:0] inc_w  = opa_i + ONE16;
	wire [15:0] dec_w  = opa_i - ONE16;
	wire [15:0] abx_w  = opa_i + {HI_ZERO, opb_i[7:0]};
	wire [15:0] logic_w = (op_i == OP_AND) ? (opa_i & opb_i)
		: (op_i == OP_OR) ? (opa_i | opb_i)
		: (op_i == OP_EOR) ? (opa_i ^ opb_i) : opb_i;

	always_comb begin
		ccr_d    = ccr_q;
		result_d = result_q;
		we_d     = 1'b0;
		if (op_valid_i) begin
			case (op_i)
				OP_ADD, OP_ADC: begin
					result_d     = sum_r;
					we_d         = 1'b1;
					ccr_d[BIT_C] = carry_at(sum_w, op_wide_i);
					ccr_d[BIT_V] = (a_m == b_m)
						&& (top_bit(sum_r, op_wide_i) != a_m);
					ccr_d[BIT_Z] = is_zero(sum_r, op_wide_i);
					ccr_d[BIT_N] = top_bit(sum_r, op_wide_i);
					if (!op_wide_i) begin
						ccr_d[BIT_H] = half_w;
					end
				end
				OP_SUB, OP_SBC, OP_CMP: begin
					result_d     = (op_i == OP_CMP) ? result_q : dif_r;
					we_d         = (op_i != OP_CMP);
					ccr_d[BIT_C] = carry_at(dif_w, op_wide_i);
					ccr_d[BIT_V] = (a_m != b_m)
						&& (top_bit(dif_r, op_wide_i) != a_m);
					ccr_d[BIT_Z] = is_zero(dif_r, op_wide_i);
					ccr_d[BIT_N] = top_bit(dif_r, op_wide_i);
				end
				OP_AND, OP_OR, OP_EOR, OP_LOAD: begin
					result_d     = fit(logic_w, op_wide_i);
					we_d         = 1'b1;
					ccr_d[BIT_V] = 1'b0;
					ccr_d[BIT_Z] = is_zero(logic_w, op_wide_i);
					ccr_d[BIT_N] = top_bit(logic_w, op_wide_i);
				end
				OP_INC_IDX, OP_DEC_IDX: begin
					result_d     = (op_i == OP_INC_IDX) ? inc_w : dec_w;
					we_d         = 1'b1;
					ccr_d[BIT_Z] = (op_i == OP_INC_IDX) ? (inc_w == 16'h0000)
						: (dec_w == 16'h0000);
				end
				OP_ADD_B_IDX: begin
					result_d = abx_w;
					we_d     = 1'b1;
				end
				OP_XFER: begin
					result_d = opa_i;
					we_d     = 1'b1;
				end
				OP_ASL, OP_LSR, OP_ROL, OP_ROR: begin
					result_d     = sh_r;
					we_d         = 1'b1;
					ccr_d[BIT_C] = sh_c;
					ccr_d[BIT_N] = top_bit(sh_r, op_wide_i);
					ccr_d[BIT_Z] = is_zero(sh_r, op_wide_i);
					ccr_d[BIT_V] = top_bit(sh_r, op_wide_i) ^ sh_c;
				end
				OP_MUL: begin
					result_d     = mul_w;
					we_d         = 1'b1;
					ccr_d[BIT_C] = mul_w[7];
				end
				OP_DIV: begin
					result_d     = div_w;
					we_d         = 1'b1;
					ccr_d[BIT_C] = div_zero;
					ccr_d[BIT_V] = 1'b0;
					ccr_d[BIT_Z] = (div_w == 16'h0000);
				end
				OP_TAP, OP_RTI: begin
					// the pin mask may drop here but never rise
					ccr_d        = opa_i[7:0];
					ccr_d[BIT_X] = ccr_q[BIT_X] & opa_i[BIT_X];
				end
				OP_CLI: ccr_d[BIT_I] = 1'b0;
				OP_SEI: ccr_d[BIT_I] = 1'b1;
				OP_IRQ_ACK: ccr_d[BIT_I] = 1'b1;
				OP_NONMASKABLE_REQUEST_PIN_ACK: begin
					ccr_d[BIT_I] = 1'b1;
					ccr_d[BIT_X] = 1'b1;
				end
				default: ccr_d = ccr_q;
			endcase
		end
	end

	wire stop_op = op_valid_i && (op_i == OP_STOP);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ccr_q        <= FLAGS_RESET;
			result_q     <= 16'h0000;
			we_q         <= 1'b0;
			stop_enter_q <= 1'b0;
			stop_nop_q   <= 1'b0;
		end else begin
			ccr_q        <= ccr_d;
			result_q     <= result_d;
			we_q         <= we_d;
			stop_enter_q <= stop_op && !ccr_q[BIT_S];
			stop_nop_q   <= stop_op && ccr_q[BIT_S];
		end
	end
	assign irq_take_o  = !irq_q2 && !ccr_q[BIT_I];
	assign nonmaskable_request_pin_take_o = !nonmaskable_request_pin_q2 && !ccr_q[BIT_X];

	// ------------------------------------------------------------
	// opcode paging and operand collection
	// ------------------------------------------------------------
	typedef enum {ST_FIRST, ST_OPCODE, ST_OPERAND, ST_EVAL} dec_state_t;
	dec_state_t state_q;
	page_t      page_q;
	mode_t      mode_q;
	logic [7:0] opc_q, b0_q, b1_q;
	logic [1:0] left_q;
	logic [2:0] len_q;
	logic [15:0] imm_q, next_q;
	addr_if ai ();
	ea_former u_ea (.port(ai));

	wire take = fetch_valid_i && fetch_ready_o;
	wire [3:0] hi_n = fetch_byte_i[7:4];
	wire [3:0] lo_n = fetch_byte_i[3:0];
	wire pre_hit = (fetch_byte_i == PREBYTE_P1) || (fetch_byte_i ==
		PREBYTE_P2) || (fetch_byte_i == PREBYTE_P3);
	wire page_sel_y = (page_q == PAGE1) || (page_q == PAGE3);
	wire bit_dir = (hi_n == 4'h1) && (lo_n >= 4'h2) && (lo_n <= 4'h5);
	wire bit_ind = (hi_n == 4'h1) && (lo_n >= 4'hC);
	wire bit_rel = (hi_n == 4'h1) && (lo_n[1] == 1'b1);
	wire imm_wide = (lo_n == 4'h3) || (lo_n == 4'hC) || (lo_n == 4'hE);
	wire mode_t dec_mode = (hi_n == 4'h2 || (page_q == PAGE0
		&& fetch_byte_i == OPC_BSR)) ? MODE_REL
		: (hi_n == 4'h8 || hi_n == 4'hC) ? MODE_IMM
		: (hi_n == 4'h9 || hi_n == 4'hD || bit_dir) ? MODE_DIR
		: (hi_n == 4'h6 || hi_n == 4'hA || hi_n == 4'hE || bit_ind)
			? MODE_IND
		: (hi_n == 4'h7 || hi_n == 4'hB || hi_n == 4'hF) ? MODE_EXT
		: MODE_INH;
	wire [1:0] base_cnt = (dec_mode == MODE_INH) ? 2'd0
		: (dec_mode == MODE_EXT || (dec_mode == MODE_IMM && imm_wide))
			? 2'd2 : 2'd1;
	wire [1:0] dec_cnt = base_cnt + ((bit_dir || bit_ind) ? 2'd1 : 2'd0)
		+ ((bit_dir || bit_ind) && bit_rel ? 2'd1 : 2'd0);

	// first operand byte lands in b0, second in b1, a third is ignored
	logic [1:0] cnt_q;
	wire [1:0] dec_left_first = cnt_q;
	wire b1_done = (cnt_q - left_q) >= 2'd2;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'd0;
		end else if (take && state_q != ST_OPERAND && !(state_q ==
			ST_FIRST && pre_hit)) begin
			cnt_q <= dec_cnt;
		end
	end

	assign fetch_ready_o = (state_q != ST_EVAL);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_FIRST;
			page_q  <= PAGE0;
			mode_q  <= MODE_INH;
			opc_q   <= 8'h00;
			b0_q    <= 8'h00;
			b1_q    <= 8'h00;
			left_q  <= 2'd0;
			len_q   <= 3'h0;
			imm_q   <= 16'h0000;
			next_q  <= 16'h0000;
		end else if (state_q == ST_EVAL) begin
			state_q <= ST_FIRST;
		end else if (take) begin
			next_q <= fetch_addr_i + ONE16;
			len_q  <= (state_q == ST_FIRST) ? LEN_ONE : len_q + LEN_ONE;
			if (state_q == ST_FIRST && pre_hit) begin
				page_q  <= (fetch_byte_i == PREBYTE_P1) ? PAGE1
					: (fetch_byte_i == PREBYTE_P2) ? PAGE2 : PAGE3;
				state_q <= ST_OPCODE;
			end else if (state_q == ST_OPERAND) begin
				b0_q    <= (left_q == dec_left_first) ? fetch_byte_i : b0_q;
				b1_q    <= (left_q != dec_left_first) && !b1_done
					? fetch_byte_i : b1_q;
				left_q  <= left_q - 2'd1;
				state_q <= (left_q == 2'd1) ? ST_EVAL : ST_OPERAND;
			end else begin
				if (state_q == ST_FIRST) begin
					page_q <= PAGE0;
				end
				opc_q   <= fetch_byte_i;
				mode_q  <= dec_mode;
				left_q  <= dec_cnt;
				imm_q   <= fetch_addr_i + ONE16;
				state_q <= (dec_cnt == 2'd0) ? ST_EVAL : ST_OPERAND;
			end
		end
	end
	// ------------------------------------------------------------
	// decode results
	// ------------------------------------------------------------
	assign ai.mode       = mode_q;
	assign ai.use_y      = page_sel_y;
	assign ai.taken      = cond_true(opc_q[3:0], ccr_q)
		|| (opc_q == OPC_BSR);
	assign ai.byte0      = b0_q;
	assign ai.byte1      = b1_q;
	assign ai.first_idx  = first_index_reg_i;
	assign ai.second_idx = second_index_reg_i;
	assign ai.imm_addr   = imm_q;
	assign ai.next_addr  = next_q;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			decode_done_o  <= 1'b0;
			ea_o           <= 16'h0000;
			ea_valid_o     <= 1'b0;
			branch_taken_o <= 1'b0;
		end else begin
			decode_done_o  <= (state_q == ST_EVAL);
			ea_o           <= (state_q == ST_EVAL) ? ai.ea : ea_o;
			ea_valid_o     <= (state_q == ST_EVAL) && ai.ea_en;
			branch_taken_o <= (state_q == ST_EVAL) && (mode_q == MODE_REL)
				&& ai.taken;
		end
	end
	assign page_o      = page_q;
	assign opcode_o    = opc_q;
	assign mode_o      = mode_q;
	assign instr_len_o = len_q;
	assign result_o    = result_q;
	assign result_we_o = we_q;
	assign condition_flags_register_o = ccr_q;
	assign stop_enter_o = stop_enter_q;
	assign stop_nop_o   = stop_nop_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);
	a_irq_ack_mask: assert property (op_valid_i && op_i == OP_IRQ_ACK |=>
		ccr_q[BIT_I]) else $error("maskable gate not set on acknowledge");
	a_nonmaskable_request_pin_ack_masks: assert property (op_valid_i && op_i == OP_NONMASKABLE_REQUEST_PIN_ACK
		|=> ccr_q[BIT_I] && ccr_q[BIT_X]) else $error("masks not set");
	a_x_no_hw_clear: assert property ($fell(ccr_q[BIT_X]) |->
		$past(op_valid_i) && ($past(op_i) == OP_TAP
		|| $past(op_i) == OP_RTI)) else $error("pin mask cleared by hw");
	a_i_gate_holds: assert property (ccr_q[BIT_I] |-> !irq_take_o)
		else $error("maskable taken while gated");
	a_idx_z_only: assert property (op_valid_i && (op_i == OP_INC_IDX
		|| op_i == OP_DEC_IDX) |=>
		(ccr_q & 8'hFB) == ($past(ccr_q) & 8'hFB)) else $error("flags moved");
	a_xfer_keeps: assert property (op_valid_i && op_i == OP_XFER |=>
		$stable(ccr_q)) else $error("transfer changed flags");
	a_stop_veto: assert property (op_valid_i && op_i == OP_STOP
		&& ccr_q[BIT_S] |=> stop_nop_o && !stop_enter_o)
		else $error("stop not vetoed");
	a_direct_page: assert property (decode_done_o && ea_valid_o
		&& mode_o == MODE_DIR |-> ea_o[15:8] == DIRECT_HI)
		else $error("direct address outside low page");
	a_inherent_no_ea: assert property (decode_done_o &&
		mode_o == MODE_INH |-> !ea_valid_o) else $error("inherent ea");
	a_len_bound: assert property (decode_done_o |-> instr_len_o >= LEN_ONE
		&& instr_len_o <= 3'h5) else $error("instruction length off");
endmodule

//--- testbench/program_memory_model.sv
// program memory that streams one instruction into the fetch port
// assumes bytes are taken on rising edges where valid and ready meet
`timescale 1ns/10ps
module program_memory_model (
	input  wire logic        core_clk_i,
	input  wire logic        start_i,
	input  wire logic [15:0] base_i,
	input  wire logic [2:0]  len_i,
	input  wire logic        fetch_ready_i,
	output logic             fetch_valid_o,
	output logic [7:0]       fetch_byte_o,
	output logic [15:0]      fetch_addr_o
);
	logic [7:0]  mem [0:255];
	logic [2:0]  left_q;
	logic [15:0] addr_q;
	logic        took;
	logic        go;
	initial begin
		left_q = 3'h0;
		addr_q = 16'h0000;
		fetch_valid_o = 1'b0;
		fetch_byte_o = 8'h00;
		fetch_addr_o = 16'h0000;
	end
	// bytes go out in rising address order, word high byte first
	always @(posedge core_clk_i) begin
		took = fetch_valid_o && fetch_ready_i;
		go = start_i;
		#1;
		if (go) begin
			addr_q = base_i;
			left_q = len_i;
		end else if (took) begin
			addr_q = addr_q + 16'h0001;
			left_q = left_q - 3'h1;
		end
		fetch_valid_o = (left_q != 3'h0);
		fetch_addr_o = addr_q;
		// idle bus toggles so a stale byte is never mistaken for data
		fetch_byte_o = fetch_valid_o ? mem[addr_q[7:0]] : ~fetch_byte_o;
	end
endmodule

//--- testbench/cpu_flags_and_address_modes_test.sv
// self-checking bench: op port and fetch port driven by call sequences
// assumes a single 100 MHz clock and the program memory model
`timescale 1ns/10ps
module cpu_flags_and_address_modes_test;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic op_valid_i = 1'b0;
	logic op_wide_i = 1'b0;
	logic [15:0] opa_i = 16'h0000;
	logic [15:0] opb_i = 16'h0000;
	cpu_flags_pkg::alu_op_t op_i = cpu_flags_pkg::OP_NONE;
	logic start_i = 1'b0;
	logic [15:0] base_i = 16'h0000;
	logic [2:0] len_i = 3'h0;
	logic fetch_valid_i, fetch_ready_o, decode_done_o, ea_valid_o;
	logic branch_taken_o, result_we_o, irq_take_o, nonmaskable_request_pin_take_o;
	logic stop_enter_o, stop_nop_o;
	logic [7:0] fetch_byte_i, opcode_o, condition_flags_register_o;
	logic [15:0] fetch_addr_i, ea_o, result_o;
	logic [2:0] instr_len_o;
	cpu_flags_pkg::page_t page_o;
	cpu_flags_pkg::mode_t mode_o;
	int n_fail = 0;
	int n_compared = 0;
	always #5 core_clk_i = ~core_clk_i;
	cpu_flags_and_address_modes cpu_flags_and_address_modes_i (.*,
		.irq_request_n_i(1'b0), .nonmaskable_request_pin_n_i(1'b0),
		.first_index_reg_i(16'h1020), .second_index_reg_i(16'h2000));
	program_memory_model program_memory_model_i (.core_clk_i, .start_i,
		.base_i, .len_i, .fetch_ready_i(fetch_ready_o),
		.fetch_valid_o(fetch_valid_i), .fetch_byte_o(fetch_byte_i),
		.fetch_addr_o(fetch_addr_i));
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic do_reset();
		rst_n_i = 1'b0;
		repeat (10) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask
	// we: 0 no write, 1 write with r, 2 not looked at
	task automatic op(input cpu_flags_pkg::alu_op_t o, input logic w,
		input logic [15:0] a, input logic [15:0] b, input logic [7:0] fl,
		input logic [1:0] we, input logic [15:0] r);
		op_i = o;
		op_wide_i = w;
		opa_i = a;
		opb_i = b;
		op_valid_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		op_valid_i = 1'b0;
		chk(condition_flags_register_o, fl);
		if (we != 2'h2)
			chk(result_we_o, we[0]);
		if (we == 2'h1)
			chk(result_o, r);
	endtask
	// ea bit 16 asks for the address to be compared
	task automatic dec(input logic [15:0] base, input logic [39:0] b,
		input logic [2:0] n, input cpu_flags_pkg::page_t pg,
		input cpu_flags_pkg::mode_t m, input logic [16:0] ea,
		input logic bt);
		int i;
		for (i = 0; i < n; i++)
			program_memory_model_i.mem[base[7:0] + i[7:0]] = b[39-8*i -: 8];
		base_i = base;
		len_i = n;
		start_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		start_i = 1'b0;
		for (i = 0; i < 20 && decode_done_o !== 1'b1; i++) begin
			@(posedge core_clk_i);
			#1;
		end
		chk(decode_done_o, 1'b1);
		chk(page_o, pg);
		chk(mode_o, m);
		chk(instr_len_o, n);
		chk(branch_taken_o, bt);
		if (ea[16])
			chk({ea_valid_o, ea_o}, ea);
		if (m == cpu_flags_pkg::MODE_INH)
			chk(ea_valid_o, 1'b0);
	endtask
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial begin
		do_reset();
		chk(condition_flags_register_o,
			cpu_flags_pkg::FLAGS_RESET);
		chk(irq_take_o, 1'b0);
		chk(nonmaskable_request_pin_take_o, 1'b0);
		op(cpu_flags_pkg::OP_TAP, 0, 16'h0, 16'h0, 8'h00, 2, 0);
		repeat (3) @(posedge core_clk_i);
		#1;
		chk(irq_take_o, 1'b1);
		chk(nonmaskable_request_pin_take_o, 1'b1);
		op(cpu_flags_pkg::OP_ADD, 0, 16'h0F, 16'h01,
			8'h20, 1, 16'h10);
		op(cpu_flags_pkg::OP_ADD, 0, 16'h80, 16'h80,
			8'h07, 1, 16'h0);
		op(cpu_flags_pkg::OP_CMP, 0, 16'h10, 16'h20,
			8'h09, 0, 0);
		op(cpu_flags_pkg::OP_INC_IDX, 1, 16'hFFFF, 0,
			8'h0D, 1, 0);
		op(cpu_flags_pkg::OP_ADD_B_IDX, 1, 16'h1234, 1,
			8'h0D, 1, 16'h1235);
		op(cpu_flags_pkg::OP_TAP, 0, 16'h40, 0, 8'h00, 2, 0);
		op(cpu_flags_pkg::OP_NONMASKABLE_REQUEST_PIN_ACK, 0, 0, 0, 8'h50, 2, 0);
		op(cpu_flags_pkg::OP_RTI, 0, 16'h00, 0, 8'h00, 2, 0);
		op(cpu_flags_pkg::OP_STOP, 0, 0, 0, 8'h00, 2, 0);
		chk(stop_enter_o, 1'b1);
		op(cpu_flags_pkg::OP_TAP, 0, 16'h80, 0, 8'h80, 2, 0);
		op(cpu_flags_pkg::OP_STOP, 0, 0, 0, 8'h80, 2, 0);
		chk({stop_enter_o, stop_nop_o}, 2'h1);
		op(cpu_flags_pkg::OP_IRQ_ACK, 0, 0, 0, 8'h90, 2, 0);
		op(cpu_flags_pkg::OP_CLI, 0, 0, 0, 8'h80, 2, 0);
		op(cpu_flags_pkg::OP_SEI, 0, 0, 0, 8'h90, 2, 0);
		op(cpu_flags_pkg::OP_AND, 0, 16'hF0, 16'h0F,
			8'h94, 1, 0);
		op(cpu_flags_pkg::OP_LSR, 0, 16'h01, 0, 8'h97, 1, 0);
		op(cpu_flags_pkg::OP_ROR, 0, 16'h02, 0,
			8'h9A, 1, 16'h81);
		op(cpu_flags_pkg::OP_MUL, 0, 16'h0C, 16'h0C,
			8'h9B, 1, 16'h90);
		op(cpu_flags_pkg::OP_ADC, 0, 16'h01, 16'h01,
			8'h90, 1, 16'h03);
		op(cpu_flags_pkg::OP_DIV, 1, 16'h10, 0,
			8'h91, 1, 16'hFFFF);
		op(cpu_flags_pkg::OP_DEC_IDX, 1, 16'h0001, 0,
			8'h95, 1, 0);
		op(cpu_flags_pkg::OP_XFER, 0, 16'h5A, 0,
			8'h95, 1, 16'h5A);
		op(cpu_flags_pkg::OP_SUB, 0, 16'h05, 16'h05,
			8'h94, 1, 0);
		$display("test flags done");
		dec(16'h10, 40'h9640 << 24, 2, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_DIR, 17'h10040, 0);
		dec(16'h20, 40'hB61234 << 16, 3, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_EXT, 17'h11234, 0);
		dec(16'h30, 40'hA6F0 << 24, 2, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_IND, 17'h11110, 0);
		dec(16'h38, 40'h18A680 << 16, 3, cpu_flags_pkg::PAGE1,
			cpu_flags_pkg::MODE_IND, 17'h12080, 0);
		dec(16'h40, 40'hCDA610 << 16, 3, cpu_flags_pkg::PAGE3,
			cpu_flags_pkg::MODE_IND, 17'h12010, 0);
		dec(16'h48, 40'h1A831234 << 8, 4, cpu_flags_pkg::PAGE2,
			cpu_flags_pkg::MODE_IMM, 0, 0);
		dec(16'h50, 40'h181E10017F, 5, cpu_flags_pkg::PAGE1,
			cpu_flags_pkg::MODE_IND, 17'h12010, 0);
		dec(16'h58, 40'h08 << 32, 1, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_INH, 0, 0);
		dec(16'h60, 40'h2010 << 24, 2, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_REL, 17'h10072, 1);
		dec(16'h68, 40'h20F0 << 24, 2, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_REL, 17'h1005A, 1);
		dec(16'h70, 40'h2110 << 24, 2, cpu_flags_pkg::PAGE0,
			cpu_flags_pkg::MODE_REL, 0, 0);
		$display("test decode done");
		do_reset();
		chk(condition_flags_register_o,
			cpu_flags_pkg::FLAGS_RESET);
		$display("test second reset done");
		end_sim();
	end
endmodule
